// ---- src/mas_pkg.sv ----
// Constants of the multiline serial host register block
package mas_pkg;
  localparam int NLINES = 8;
  localparam int FIFO_AW = 6;
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_DW = 15;
  localparam logic [15:0] BASE_MIN = 16'hE008;
  localparam logic [15:0] BASE_MAX = 16'hE7FE;
  localparam logic [8:0] VEC_MIN = 9'h0C0;
  localparam logic [8:0] VEC_MAX = 9'h1FE;
  localparam logic [1:0] IDX_CSR = 2'h0;
  localparam logic [1:0] IDX_RECEIVE_FIFO_OUTPUT_LPR = 2'h1;
  localparam logic [1:0] IDX_TCR = 2'h2;
  localparam logic [1:0] IDX_TDR_MSR = 2'h3;
  localparam int CSR_TX_RDY = 15;
  localparam int CSR_TIE = 14;
  localparam int CSR_ALARM = 13;
  localparam int CSR_FAE = 12;
  localparam int CSR_TLINE = 8;
  localparam int CSR_RECEIVER_DONE_FLAG = 7;
  localparam int CSR_RIE = 6;
  localparam int CSR_MSE = 5;
  localparam int CSR_CLR = 4;
  localparam int CSR_MAINT = 3;
  localparam int RB_VALID = 15;
  localparam int RB_OVR = 14;
  localparam int RB_FRM = 13;
  localparam int RB_PAR = 12;
  localparam int RB_LINE = 8;
  localparam int LPR_CLEN = 3;
  localparam int LPR_LINE = 0;
  localparam logic [3:0] ALARM_LAST = 4'hF;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLR_TIME_NS = 1000;
  localparam int CLR_CYC = (CLR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] CLR_CNT_INIT = 5'(CLR_CYC);
endpackage

// ---- src/mas_fifo_mem.sv ----
// Receive FIFO storage with registered read data
`timescale 1ns/1ps
module mas_fifo_mem
  import mas_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [FIFO_AW-1:0] wr_addr,
  input wire logic [FIFO_DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [FIFO_AW-1:0] rd_addr,
  output logic [FIFO_DW-1:0] rd_data
);
  logic [FIFO_DW-1:0] mem [FIFO_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ---- src/mas_host_regs.sv ----
// Host register side of the multiline asynchronous serial interface
// How it works
// - Base address strap in 160010-163776 octal; vector strap in 300-776 octal.
// - Writes skip read-only bits; write-only and unused bits read zero.
// - Word 1 and 3: read gives receive/modem status, write loads params/tx data.
// - Tx ready sets on enabled empty line; clears on clear or buffer load.
// - Tx interrupt enable with tx ready requests a transmit interrupt.
// - Alarm sets after 16 entries; clears on clear or buffer read.
// - Alarm enable with rx enable: alarm interrupts, receiver done does not.
// - Ready line number field; returns to line zero after clear.
// - Receiver done shows character at output; interrupts if enabled, alarm off.
// - Receive interrupt enable gates receiver interrupts; cleared by clear.
// - Master scan enable starts scanner for receivers, transmitters, FIFO.
// - Soft clear resets FIFO, channels, control; reads one while running.
// - Maintenance bit loops each transmitter output into its receiver.
// - Scan disabled holds FIFO empty; receive data invalid.
// - Each receive buffer read pops FIFO, presents next character.
// - Clear empties FIFO, zeros valid bit, keeps stale data bits.
// - Bit 14 flags overrun; stored character still valid.
// - Bit 13 flags framing error, also used for break.
// - Bit 12 flags parity error.
// - Word holds line and character; bits above length forced zero.
// - Transmit control low byte holds per-line transmit permit bits.
// - Transmit data low byte loads holding byte of ready line.
`timescale 1ns/1ps
module mas_host_regs
  import mas_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] base_strap,
  input wire logic [8:0] vec_strap,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_byte,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  output logic [8:0] int_vector,
  output logic tx_irq,
  output logic rx_irq,
  input wire logic rx_char_valid,
  input wire logic [2:0] rx_char_line,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_char_ovr,
  input wire logic rx_char_frm,
  input wire logic rx_char_par,
  input wire logic [7:0] tx_buf_empty,
  input wire logic [7:0] tx_serial,
  input wire logic [7:0] rx_pin,
  input wire logic [7:0] ring_pin,
  input wire logic [7:0] carrier_pin,
  output logic [7:0] rx_serial,
  output logic tx_load,
  output logic [2:0] tx_load_line,
  output logic [7:0] tx_load_data,
  output logic [7:0] brk,
  output logic [7:0] dtr,
  output logic lpr_load,
  output logic [15:0] lpr_data,
  output logic uart_clear,
  output logic scan_on
);
  typedef struct packed {
    logic [15:0] base;
    logic [8:0] vec;
    logic strap_done;
    logic tx_rdy;
    logic tie;
    logic alarm;
    logic fae;
    logic [2:0] tline;
    logic receive_interrupt_enable;
    logic mse;
    logic clr_busy;
    logic [4:0] clr_cnt;
    logic maint;
    logic [7:0] tcr_en;
    logic [7:0] dtr;
    logic [7:0] brk;
    logic [15:0] clen;
    logic [2:0] scan_ptr;
    logic [3:0] alarm_cnt;
    logic [FIFO_AW-1:0] wr_ptr;
    logic [FIFO_AW-1:0] rd_ptr;
    logic [FIFO_AW:0] count;
    logic fetch;
    logic out_valid;
    logic [FIFO_DW-1:0] out_data;
    logic [15:0] rdata;
    logic ack;
    logic tx_load;
    logic [2:0] tx_line;
    logic [7:0] tx_data;
    logic lpr_load;
    logic [15:0] lpr_data;
    logic tx_irq;
    logic rx_irq;
    logic [7:0] rx_s1;
    logic [7:0] rx_s2;
    logic [7:0] ri_s1;
    logic [7:0] ri_s2;
    logic [7:0] cd_s1;
    logic [7:0] cd_s2;
    logic [7:0] rx_serial;
  } mas_state_s;

  mas_state_s st_reg;
  mas_state_s st_next;
  logic push;
  logic fetch_go;
  logic [FIFO_DW-1:0] push_word;
  logic [FIFO_DW-1:0] mem_rdata;
  logic [7:0] char_mask;
  logic hit;
  logic rd_hit;
  logic wr_hit;
  logic [1:0] idx;
  logic wr_lo;
  logic wr_hi;
  logic receive_fifo_output_pop;
  logic tdr_load;

  ////////////////////////////////////////////////////////////////////
  // Receive FIFO storage
  mas_fifo_mem u_mem (
    .clk(clk),
    .wr_en(push),
    .wr_addr(st_reg.wr_ptr),
    .wr_data(push_word),
    .rd_en(fetch_go),
    .rd_addr(st_reg.rd_ptr),
    .rd_data(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.tx_load = 1'b0;
    st_next.lpr_load = 1'b0;
    // Static straps, aligned, caught once after reset
    if (!st_reg.strap_done) begin
      st_next.base = {base_strap[15:3], 3'h0};
      st_next.vec = {vec_strap[8:2], 2'h0};
      st_next.strap_done = 1'b1;
    end
    // Pin synchronisers
    st_next.rx_s1 = rx_pin;
    st_next.rx_s2 = st_reg.rx_s1;
    st_next.ri_s1 = ring_pin;
    st_next.ri_s2 = st_reg.ri_s1;
    st_next.cd_s1 = carrier_pin;
    st_next.cd_s2 = st_reg.cd_s1;
    st_next.rx_serial = st_reg.maint ? tx_serial : st_reg.rx_s2;

    // Bus decode
    hit = st_reg.strap_done && (bus_addr[15:3] == st_reg.base[15:3])
      && (st_reg.base >= BASE_MIN) && (st_reg.base <= BASE_MAX)
      && (st_reg.vec >= VEC_MIN) && (st_reg.vec <= VEC_MAX);
    idx = bus_addr[2:1];
    rd_hit = hit && bus_rd;
    wr_hit = hit && bus_wr && !bus_rd;
    wr_lo = wr_hit && (!bus_byte || !bus_addr[0]);
    wr_hi = wr_hit && (!bus_byte || bus_addr[0]);
    receive_fifo_output_pop = rd_hit && (idx == IDX_RECEIVE_FIFO_OUTPUT_LPR);
    tdr_load = wr_lo && (idx == IDX_TDR_MSR);

    // Round-robin transmit scanner
    if (st_reg.mse && !st_reg.tx_rdy) begin
      if (st_reg.tcr_en[st_reg.scan_ptr] && tx_buf_empty[st_reg.scan_ptr]) begin
        st_next.tx_rdy = 1'b1;
        st_next.tline = st_reg.scan_ptr;
      end else begin
        st_next.scan_ptr = st_reg.scan_ptr + 3'h1;
      end
    end

    // FIFO fill
    char_mask = 8'hFF >> (2'h3 - st_reg.clen[2*rx_char_line +: 2]);
    push_word = {rx_char_ovr, rx_char_frm, rx_char_par, 1'b0, rx_char_line,
      rx_char_data & char_mask};
    push = rx_char_valid && st_reg.mse && !st_reg.clr_busy
      && (st_reg.count != 7'(FIFO_DEPTH));
    fetch_go = st_reg.mse && !st_reg.out_valid && !st_reg.fetch && (st_reg.count != '0);
    if (push) begin
      st_next.wr_ptr = st_reg.wr_ptr + 6'h1;
    end
    if (fetch_go) begin
      st_next.rd_ptr = st_reg.rd_ptr + 6'h1;
    end
    st_next.fetch = fetch_go;
    st_next.count = st_reg.count + 7'(push) - 7'(fetch_go);
    if (st_reg.fetch) begin
      st_next.out_valid = 1'b1;
      st_next.out_data = mem_rdata;
    end

    // Register reads
    if (rd_hit) begin
      st_next.ack = 1'b1;
      unique case (idx)
        IDX_CSR: st_next.rdata = {st_reg.tx_rdy, st_reg.tie, st_reg.alarm, st_reg.fae,
          1'b0, st_reg.tline, st_reg.out_valid && st_reg.mse, st_reg.receive_interrupt_enable, st_reg.mse,
          st_reg.clr_busy, st_reg.maint, 3'h0};
        IDX_RECEIVE_FIFO_OUTPUT_LPR: st_next.rdata = {st_reg.out_valid && st_reg.mse,
          st_reg.out_data};
        IDX_TCR: st_next.rdata = {st_reg.dtr, st_reg.tcr_en};
        IDX_TDR_MSR: st_next.rdata = {st_reg.cd_s2, st_reg.ri_s2};
      endcase
    end
    if (receive_fifo_output_pop) begin
      // Keep a word already in flight
      st_next.out_valid = st_reg.fetch;
      st_next.alarm = 1'b0;
    end
    // Alarm count, set wins over the read clear
    if (push) begin
      st_next.alarm_cnt = st_reg.alarm_cnt + 4'h1;
      if (st_reg.alarm_cnt == ALARM_LAST) begin
        st_next.alarm = 1'b1;
      end
    end

    // Register writes
    if (wr_hit) begin
      st_next.ack = 1'b1;
    end
    if (idx == IDX_CSR) begin
      if (wr_lo) begin
        st_next.receive_interrupt_enable = bus_wdata[CSR_RIE];
        st_next.mse = bus_wdata[CSR_MSE];
        st_next.maint = bus_wdata[CSR_MAINT];
        if (bus_wdata[CSR_CLR]) begin
          st_next.clr_busy = 1'b1;
          st_next.clr_cnt = CLR_CNT_INIT;
        end
      end
      if (wr_hi) begin
        st_next.tie = bus_wdata[CSR_TIE];
        st_next.fae = bus_wdata[CSR_FAE];
      end
    end
    if (wr_hit && idx == IDX_RECEIVE_FIFO_OUTPUT_LPR) begin
      st_next.lpr_load = 1'b1;
      st_next.lpr_data = bus_wdata;
      st_next.clen[2*bus_wdata[LPR_LINE +: 3] +: 2] = bus_wdata[LPR_CLEN +: 2];
    end
    if (idx == IDX_TCR) begin
      if (wr_lo) begin
        st_next.tcr_en = bus_wdata[7:0];
      end
      if (wr_hi) begin
        st_next.dtr = bus_wdata[15:8];
      end
    end
    if (tdr_load) begin
      st_next.tx_load = 1'b1;
      st_next.tx_line = st_reg.tline;
      st_next.tx_data = bus_wdata[7:0];
      st_next.tx_rdy = 1'b0;
      st_next.scan_ptr = st_reg.tline + 3'h1;
    end
    if (wr_hi && idx == IDX_TDR_MSR) begin
      st_next.brk = bus_wdata[15:8];
    end

    // Scan off holds FIFO empty
    if (!st_reg.mse) begin
      st_next.count = '0;
      st_next.wr_ptr = st_reg.rd_ptr;
      st_next.fetch = 1'b0;
      st_next.out_valid = 1'b0;
    end

    // Soft clear in progress
    if (st_reg.clr_busy) begin
      st_next.clr_cnt = st_reg.clr_cnt - 5'h1;
      st_next.clr_busy = (st_reg.clr_cnt != 5'h1);
      st_next.tx_rdy = 1'b0;
      st_next.tie = 1'b0;
      st_next.alarm = 1'b0;
      st_next.fae = 1'b0;
      st_next.tline = 3'h0;
      st_next.receive_interrupt_enable = 1'b0;
      st_next.mse = 1'b0;
      st_next.maint = 1'b0;
      st_next.tcr_en = 8'h00;
      st_next.brk = 8'h00;
      st_next.clen = 16'h0000;
      st_next.scan_ptr = 3'h0;
      st_next.alarm_cnt = 4'h0;
      st_next.count = '0;
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.fetch = 1'b0;
      st_next.out_valid = 1'b0;
    end

    // Interrupt requests
    st_next.tx_irq = st_reg.tie && st_reg.tx_rdy;
    st_next.rx_irq = st_reg.receive_interrupt_enable && (st_reg.fae ? st_reg.alarm
      : (st_reg.out_valid && st_reg.mse));
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign bus_ack = st_reg.ack;
  assign int_vector = st_reg.vec;
  assign tx_irq = st_reg.tx_irq;
  assign rx_irq = st_reg.rx_irq;
  assign rx_serial = st_reg.rx_serial;
  assign tx_load = st_reg.tx_load;
  assign tx_load_line = st_reg.tx_line;
  assign tx_load_data = st_reg.tx_data;
  assign brk = st_reg.brk;
  assign dtr = st_reg.dtr;
  assign lpr_load = st_reg.lpr_load;
  assign lpr_data = st_reg.lpr_data;
  assign uart_clear = st_reg.clr_busy;
  assign scan_on = st_reg.mse;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tx_irq;
    st_reg.tie && st_reg.tx_rdy |=> tx_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");

  property p_pop;
    receive_fifo_output_pop && !st_reg.fetch && !push |=> !st_reg.out_valid && !st_reg.alarm && bus_ack;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not pop");

  property p_receiver_done_flag_irq;
    st_reg.receive_interrupt_enable && !st_reg.fae && st_reg.out_valid && st_reg.mse |=> rx_irq;
  endproperty
  a_receiver_done_flag_irq: assert property (p_receiver_done_flag_irq) else $error("receiver_done_flag irq missing");

  property p_alarm_only;
    st_reg.receive_interrupt_enable && st_reg.fae && !st_reg.alarm |=> !rx_irq;
  endproperty
  a_alarm_only: assert property (p_alarm_only) else $error("receiver_done_flag irq under alarm");

  property p_scan_off;
    !st_reg.mse |=> st_reg.count == '0 && !st_reg.out_valid;
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("fifo not held empty");

  property p_clear_len;
    wr_lo && idx == IDX_CSR && bus_wdata[CSR_CLR] && !st_reg.clr_busy
      |=> st_reg.clr_busy[*8];
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("clear too short");

  property p_tdr_load;
    tdr_load |=> tx_load && !st_reg.tx_rdy && tx_load_line == $past(st_reg.tline);
  endproperty
  a_tdr_load: assert property (p_tdr_load) else $error("buffer load wrong");

  property p_loop;
    st_reg.maint |=> rx_serial == $past(tx_serial);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback broken");

  property p_clear_line;
    st_reg.clr_busy |=> st_reg.tline == 3'h0 && !st_reg.mse && !st_reg.receive_interrupt_enable;
  endproperty
  a_clear_line: assert property (p_clear_line) else $error("clear left state");

  property p_zero_bits;
    rd_hit && idx == IDX_CSR |=> bus_ack && bus_rdata[11] == 1'b0 && bus_rdata[2:0] == 3'h0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits set");
endmodule

// ---- sim/mas_line_model.sv ----
// Behavioural model of the transmitter side facing the host register block
`timescale 1ns/1ps
module mas_line_model
  import mas_pkg::*;
#(
  parameter int BUSY_CYC = 100
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_load,
  input wire logic [2:0] tx_load_line,
  input wire logic [7:0] tx_load_data,
  input wire logic [7:0] brk,
  output logic [7:0] tx_buf_empty,
  output logic [7:0] tx_serial,
  output logic [2:0] last_line,
  output logic [7:0] last_data
);
  int busy [NLINES];

  // Break sends space, otherwise idle mark
  assign tx_serial = ~brk;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buf_empty <= 8'hFF;
      last_line <= 3'h0;
      last_data <= 8'h00;
      foreach (busy[i]) busy[i] <= 0;
    end else begin
      for (int i = 0; i < NLINES; i++) begin
        if (busy[i] == 1) tx_buf_empty[i] <= 1'b1;
        if (busy[i] > 0) busy[i] <= busy[i] - 1;
      end
      if (tx_load) begin
        tx_buf_empty[tx_load_line] <= 1'b0;
        busy[tx_load_line] <= BUSY_CYC;
        last_line <= tx_load_line;
        last_data <= tx_load_data;
      end
    end
  end
endmodule

// ---- sim/test_multiline_async_serial_host_registers.sv ----
// Self-checking bench of the multiline serial host register block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_multiline_async_serial_host_registers
  import mas_pkg::*;
();
  localparam logic [15:0] BASE = 16'hE040;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_rd = 1'b0, bus_wr = 1'b0, bus_byte = 1'b0, rx_char_valid = 1'b0;
  logic rx_char_ovr = 1'b0, rx_char_frm = 1'b0, rx_char_par = 1'b0;
  logic [2:0] rx_char_line = 3'h0;
  logic [7:0] rx_char_data = 8'h00;
  logic [7:0] rx_pin = 8'hA5;
  logic [15:0] bus_rdata, lpr_data, rd;
  logic bus_ack, tx_irq, rx_irq, tx_load, lpr_load, uart_clear, scan_on;
  logic [8:0] int_vector;
  logic [2:0] tx_load_line, last_line, ln;
  logic [7:0] tx_load_data, brk, dtr, rx_serial, tx_buf_empty, tx_serial, last_data;
  int fail_count = 0;
  int tests_run = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  mas_host_regs u_mas_host_regs (.clk, .rst, .base_strap(BASE), .vec_strap(9'h0C0),
    .bus_addr, .bus_rd, .bus_wr, .bus_byte, .bus_wdata, .bus_rdata, .bus_ack,
    .int_vector, .tx_irq, .rx_irq, .rx_char_valid, .rx_char_line, .rx_char_data,
    .rx_char_ovr, .rx_char_frm, .rx_char_par, .tx_buf_empty, .tx_serial, .rx_pin,
    .ring_pin(8'h3C), .carrier_pin(8'hC3), .rx_serial, .tx_load, .tx_load_line,
    .tx_load_data, .brk, .dtr, .lpr_load, .lpr_data, .uart_clear, .scan_on);

  mas_line_model u_mas_line_model (.clk, .rst, .tx_load, .tx_load_line, .tx_load_data,
    .brk, .tx_buf_empty, .tx_serial, .last_line, .last_data);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One bus cycle; acknowledge expected one edge after the request edge
  task automatic bus(input logic [3:0] off, input logic wr, input logic byt,
      input logic [15:0] wd, input logic hit);
    @(posedge clk);
    bus_addr <= BASE + {12'h000, off};
    bus_wr <= wr;
    bus_rd <= !wr;
    bus_byte <= byt;
    bus_wdata <= wd;
    @(posedge clk);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    @(negedge clk);
    rd = bus_rdata;
    `CHK("bus_ack", hit, bus_ack)
  endtask

  task automatic wr(input logic [3:0] off, input logic [15:0] wd);
    bus(off, 1'b1, 1'b0, wd, 1'b1);
  endtask

  task automatic rdw(input logic [3:0] off);
    bus(off, 1'b0, 1'b0, 16'h0000, 1'b1);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rxc(input logic [2:0] l, input logic [7:0] d, input logic [2:0] f);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char_line <= l;
    rx_char_data <= d;
    {rx_char_ovr, rx_char_frm, rx_char_par} <= f;
    @(posedge clk);
    rx_char_valid <= 1'b0;
  endtask

  // Bounded poll for transmitter ready
  task automatic poll_tx;
    int n;
    n = 0;
    rdw(4'h0);
    while (rd[15] !== 1'b1 && n < 30) begin
      n++;
      rdw(4'h0);
    end
    if (rd[15] !== 1'b1) begin
      fail_count++;
      $display("ERROR poll_tx expected 1 seen %b", rd[15]);
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(2);
    `CHK("int_vector", 9'h0C0, int_vector)
    rdw(4'h0);
    `CHK("csr_reset", 16'h0000, rd)
    bus(4'h8, 1'b0, 1'b0, 16'h0000, 1'b0);
    wr(4'h0, 16'hA08F);
    rdw(4'h0);
    `CHK("csr_ro_bits", 16'h0008, rd)
    bus(4'h7, 1'b1, 1'b1, 16'h0100, 1'b1);
    cyc(4);
    `CHK("brk", 8'h01, brk)
    `CHK("loop", 8'hFE, rx_serial)
    wr(4'h0, 16'h0000);
    cyc(4);
    `CHK("no_loop", 8'hA5, rx_serial)
    rdw(4'h6);
    `CHK("modem_status", 16'hC33C, rd)
    $display("test registers done");
    wr(4'h2, 16'h101A);
    `CHK("lpr_load", 1'b1, lpr_load)
    cyc(2);
    `CHK("lpr_data", 16'h101A, lpr_data)
    wr(4'h0, 16'h0060);
    `CHK("scan_on", 1'b1, scan_on)
    rxc(3'd5, 8'hFF, 3'b101);
    rxc(3'd2, 8'hC3, 3'b010);
    cyc(4);
    rdw(4'h0);
    `CHK("receiver_done_flag", 1'b1, rd[7])
    `CHK("rx_irq", 1'b1, rx_irq)
    rdw(4'h2);
    `CHK("rbuf0", 16'hD51F, rd)
    cyc(4);
    rdw(4'h2);
    `CHK("rbuf1", 16'hA2C3, rd)
    cyc(4);
    rdw(4'h2);
    `CHK("receive_fifo_output_empty", 1'b0, rd[15])
    rdw(4'h0);
    `CHK("receiver_done_flag_clr", 1'b0, rd[7])
    wr(4'h0, 16'h0020);
    rxc(3'd1, 8'h11, 3'b000);
    cyc(4);
    `CHK("rx_irq_off", 1'b0, rx_irq)
    $display("test receive done");
    wr(4'h0, 16'h5068);
    wr(4'h0, 16'h0010);
    rdw(4'h0);
    `CHK("clr_busy", 1'b1, rd[4])
    `CHK("uart_clear", 1'b1, uart_clear)
    cyc(CLR_CYC);
    rdw(4'h0);
    `CHK("csr_clr", 16'h0000, rd)
    rdw(4'h2);
    `CHK("valid_clr", 1'b0, rd[15])
    `CHK("stale_data", 15'h0111, rd[14:0])
    $display("test clear done");
    wr(4'h0, 16'h1060);
    repeat (15) rxc(3'd0, 8'h07, 3'b000);
    cyc(4);
    rdw(4'h0);
    `CHK("alarm15", 1'b0, rd[13])
    `CHK("irq_fae", 1'b0, rx_irq)
    rxc(3'd0, 8'h07, 3'b000);
    cyc(4);
    rdw(4'h0);
    `CHK("alarm16", 1'b1, rd[13])
    `CHK("irq_alarm", 1'b1, rx_irq)
    rdw(4'h2);
    rdw(4'h0);
    `CHK("alarm_rd", 1'b0, rd[13])
    wr(4'h0, 16'h0000);
    cyc(4);
    rdw(4'h2);
    `CHK("scan_off", 1'b0, rd[15])
    wr(4'h0, 16'h0020);
    cyc(6);
    rdw(4'h2);
    `CHK("held_empty", 1'b0, rd[15])
    $display("test alarm done");
    wr(4'h4, 16'h5A18);
    wr(4'h0, 16'h4020);
    poll_tx();
    `CHK("tx_rdy", 1'b1, rd[15])
    `CHK("tx_irq", 1'b1, tx_irq)
    ln = rd[10:8];
    `CHK("tx_line", 1'b1, (ln == 3'd3 || ln == 3'd4))
    wr(4'h6, 16'h0041);
    cyc(2);
    `CHK("tx_data", 8'h41, last_data)
    `CHK("tx_ld_line", ln, last_line)
    poll_tx();
    `CHK("rr_line", 3'd7 - ln, rd[10:8])
    rdw(4'h4);
    `CHK("tcr", 16'h5A18, rd)
    wr(4'h4, 16'h5A00);
    wr(4'h6, 16'h0042);
    cyc(4);
    rdw(4'h0);
    `CHK("tx_rdy_clr", 1'b0, rd[15])
    `CHK("tx_irq_clr", 1'b0, tx_irq)
    wr(4'h0, 16'h0010);
    cyc(CLR_CYC + 2);
    `CHK("dtr_kept", 8'h5A, dtr)
    rdw(4'h0);
    `CHK("tx_line0", 3'd0, rd[10:8])
    $display("test transmit done");
    finish_test();
  end
endmodule
